// file: component_responder.sv
// behavioural model of the polled serial components behind the poll link
`timescale 1ns/1ns
`default_nettype none
module component_responder (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic mute_i,
	input wire logic [7:0] dly_i,
	output logic done_o
);
	logic busy_ff = 1'b0;
	logic [7:0] cnt_ff = 8'h00;
	initial done_o = 1'b0;
	// a muted component never answers, so the block must fall back on its timeout
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (req_i === 1'b1 && mute_i !== 1'b1) begin
			busy_ff <= 1'b1;
			cnt_ff <= dly_i;
		end else if (busy_ff) begin
			if (cnt_ff == 8'h00) begin
				done_o <= 1'b1;
				busy_ff <= 1'b0;
			end else begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: poller_pkg.sv
// constants, register map and types of the serial poller control and status block
`default_nettype none
package poller_pkg;
	// register indexes; the byte address is four times the index
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_SYNADDR = 3'h2;
	localparam logic [2:0] IDX_IRQ_ST = 3'h3;
	localparam logic [2:0] IDX_IRQ_MASK = 3'h4;
	localparam logic [2:0] IDX_LAST = 3'h4;
	// control word fields
	localparam int RUN_LO = 0;
	localparam int RUN_HI = 3;
	localparam int TMO_LO = 4;
	localparam int TMO_HI = 7;
	localparam int CNT_LO = 8;
	localparam int CNT_HI = 15;
	localparam logic [3:0] RUN_ON = 4'h1;
	localparam logic [3:0] TMO_MAX = 4'h9;
	localparam logic [6:0] CNT_MAX = 7'h20;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// status word values
	localparam logic [7:0] CODE_WDOG = 8'h01;
	localparam logic [7:0] CODE_SYNTAX = 8'h02;
	localparam logic [7:0] CODE_DM = 8'h15;
	localparam logic [7:0] UNIT_NONE = 8'h00;
	localparam logic [3:0] DIGIT_ERR = 4'h8;
	localparam logic [3:0] DIGIT_OK = 4'h0;
	localparam logic [3:0] FLAG_RUN = 4'h1;
	localparam logic [3:0] FLAG_STOP = 4'h0;
	localparam logic [15:0] SYNADDR_RST = 16'h0000;
	// interrupt status and mask layout
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_TMO = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// timing
	localparam int TICK_MS = 500;
	localparam int CLK_KHZ = 10000;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_REQ = 3'b010,
		ST_WAIT = 3'b100
	} poll_state_t;
endpackage
`default_nettype wire

// file: response_timer.sv
// response timer counting base ticks for one component exchange
`timescale 1ns/1ns
`default_nettype none
module response_timer (
	input wire logic clk_i,
	input wire logic rstn_i,
	timer_if.tmr tif
);
	logic active_ff;
	logic [3:0] left_ff;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			active_ff <= 1'b0;
			left_ff <= 4'h0;
		end else if (tif.start) begin
			active_ff <= 1'b1;
			left_ff <= tif.ticks;
		end else if (tif.stop) begin
			active_ff <= 1'b0;
		end else if (active_ff && tif.tick) begin
			if (left_ff == 4'h1) begin
				active_ff <= 1'b0;
			end
			left_ff <= left_ff - 4'h1;
		end
	end
	assign tif.expired = active_ff && tif.tick && left_ff == 4'h1 && !tif.stop && !tif.start; // R4
	chk_expire_last: assert property (@(posedge clk_i) disable iff (!rstn_i) // R4
		tif.expired |=> !active_ff)
		else $error("timer still active after expiry");
	cov_expire: cover property (@(posedge clk_i) disable iff (!rstn_i) tif.expired);
endmodule
`default_nettype wire

// file: serial_poller_control_status.sv
// control and status registers of the serial poller, with its poll sequencer
// Notes on behaviour
// R1: run digit written to 1 starts component polling.
// R2: a present fatal error stops polling from starting, even with run set.
// R3: run digit 0 means no component communication at all.
// R4: response timeout is (timeout digit plus one) times 500 ms.
// R5: software normally leaves the timeout digit at 0.
// R6: component count is two BCD digits, 00 to 32; that many are polled.
// R7: component count zero means no component is polled.
// R8: an error puts its two-digit code in status bits 0 to 7.
// R9: watchdog failure writes code 01, halts everything, lights fault lamp.
// R10: syntax fault stores its address, reports 02, halts polling, lights lamp.
// R11: access to a missing host address reports 15, halts, lights lamp.
// R12: an error clears the run/stop digit of the status word.
// R13: an error writes 8 into the top status digit.
// R14: without error, bits 0 to 7 show the last completed unit in BCD.
// R15: unit number reads 00 at power-up, with count zero or run off.
// R16: without error, the run digit shows 1 while running, 0 when stopped.
// R17: syntax address word keeps the first offending address found.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module serial_poller_control_status #(
	parameter int ADDR_W = 5,
	parameter int TICK_CYCLES = poller_pkg::TICK_CYCLES
) (
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic POLL_REQ_O,
	output logic [4:0] POLL_UNIT_O,
	input wire logic POLL_DONE_I,
	input wire logic WDOG_FAIL_I,
	input wire logic SYNTAX_FAULT_I,
	input wire logic [15:0] SYNTAX_ADDR_I,
	input wire logic DM_RANGE_FAULT_I,
	output logic FAULT_LAMP_O,
	output logic IRQ_O
);
	initial begin
		if (ADDR_W < 5) begin
			$error("ADDR_W must be at least 5");
		end
	end

	// two BCD digits to binary
	function automatic logic [6:0] bcd2bin(input logic [7:0] b);
		logic [6:0] tens;
		tens = 7'(b[7:4]) * 7'h0A;
		return tens + 7'(b[3:0]);
	endfunction

	// unit index 0..31 to two BCD digits
	function automatic logic [7:0] bin2bcd(input logic [4:0] v);
		logic [3:0] tens;
		logic [4:0] rest;
		tens = (v >= 5'h1E) ? 4'h3 : (v >= 5'h14) ? 4'h2 : (v >= 5'h0A) ? 4'h1 : 4'h0;
		rest = v - 5'(tens) * 5'h0A;
		return {tens, rest[3:0]};
	endfunction

	// index of the unit after idx, wrapping at the count
	function automatic logic [4:0] next_unit(input logic [4:0] idx, input logic [6:0] cnt);
		logic [6:0] up;
		up = 7'(idx) + 7'h01;
		return (up >= cnt) ? 5'h00 : up[4:0];
	endfunction

	// register state
	logic [15:0] ctrl_ff;
	logic [poller_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [poller_pkg::IRQ_W-1:0] irq_st_ff;
	logic err_ff;
	logic fatal_ff;
	logic [7:0] err_code_ff;
	logic [15:0] syn_addr_ff;
	logic syn_held_ff;
	logic [7:0] unit_ff;

	// bus state
	logic [2:0] aw_idx_ff;
	logic aw_ok_ff;
	logic aw_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic w_held_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;

	// sequencer state
	poller_pkg::poll_state_t state_ff;
	poller_pkg::poll_state_t nxt_state;
	logic [4:0] idx_ff;
	logic [4:0] nxt_idx;

	// decoded control
	logic run_req;
	logic [3:0] tmo_digit;
	logic [6:0] cnt_raw;
	logic [6:0] cnt_bin;
	logic running;
	logic [15:0] status_word;
	logic step;

	assign run_req = ctrl_ff[poller_pkg::RUN_HI:poller_pkg::RUN_LO] == poller_pkg::RUN_ON; // R1
	// digits above 9 are clamped rather than refused; software can misprogram but never stall the timer
	assign tmo_digit = (ctrl_ff[poller_pkg::TMO_HI:poller_pkg::TMO_LO] > poller_pkg::TMO_MAX) ?
		poller_pkg::TMO_MAX : ctrl_ff[poller_pkg::TMO_HI:poller_pkg::TMO_LO]; // R4
	assign cnt_raw = bcd2bin(ctrl_ff[poller_pkg::CNT_HI:poller_pkg::CNT_LO]);
	assign cnt_bin = (cnt_raw > poller_pkg::CNT_MAX) ? poller_pkg::CNT_MAX : cnt_raw; // R6
	// any error halts polling and also holds it off at start
	assign running = run_req && !err_ff && (cnt_bin != 7'h00); // R2 R3 R7 R10

	// status word
	always_comb begin
		if (err_ff) begin
			status_word = {poller_pkg::DIGIT_ERR, poller_pkg::FLAG_STOP, err_code_ff}; // R8 R12 R13
		end else begin
			status_word = {poller_pkg::DIGIT_OK, running ? poller_pkg::FLAG_RUN : poller_pkg::FLAG_STOP, unit_ff}; // R14 R16
		end
	end

	// timer link
	timer_if tif ();
	tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_div (
		.clk_i(SYS_CLK_I),
		.rstn_i(RSTN_I),
		.tif(tif)
	);
	response_timer u_tmr (
		.clk_i(SYS_CLK_I),
		.rstn_i(RSTN_I),
		.tif(tif)
	);
	assign tif.start = POLL_REQ_O;
	assign tif.ticks = tmo_digit + 4'h1; // R4
	assign tif.stop = (state_ff == poller_pkg::ST_WAIT) && (POLL_DONE_I || !running);

	// poll sequencer
	assign step = POLL_DONE_I || tif.expired;
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		case (state_ff)
			poller_pkg::ST_IDLE: begin
				if (running) begin
					nxt_state = poller_pkg::ST_REQ; // R1
					nxt_idx = 5'h00;
				end
			end
			poller_pkg::ST_REQ: begin
				nxt_state = running ? poller_pkg::ST_WAIT : poller_pkg::ST_IDLE;
			end
			poller_pkg::ST_WAIT: begin
				if (!running) begin
					nxt_state = poller_pkg::ST_IDLE; // R3
				end else if (step) begin
					nxt_state = poller_pkg::ST_REQ;
					nxt_idx = next_unit(idx_ff, cnt_bin); // R6
				end
			end
			default: begin
				nxt_state = poller_pkg::ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			state_ff <= poller_pkg::ST_IDLE;
			idx_ff <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
		end
	end
	assign POLL_REQ_O = (state_ff == poller_pkg::ST_REQ) && running; // R2 R3 R7
	assign POLL_UNIT_O = idx_ff;

	// last completed unit
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			unit_ff <= poller_pkg::UNIT_NONE; // R15
		end else if (!run_req || cnt_bin == 7'h00) begin
			unit_ff <= poller_pkg::UNIT_NONE; // R15
		end else if (state_ff == poller_pkg::ST_WAIT && POLL_DONE_I && running) begin
			unit_ff <= bin2bcd(idx_ff); // R14
		end
	end

	// error capture; a fatal error overrides an earlier syntax error
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			err_ff <= 1'b0;
			fatal_ff <= 1'b0;
			err_code_ff <= poller_pkg::UNIT_NONE;
		end else if (WDOG_FAIL_I && !fatal_ff) begin
			err_ff <= 1'b1;
			fatal_ff <= 1'b1;
			err_code_ff <= poller_pkg::CODE_WDOG; // R9
		end else if (DM_RANGE_FAULT_I && !fatal_ff) begin
			err_ff <= 1'b1;
			fatal_ff <= 1'b1;
			err_code_ff <= poller_pkg::CODE_DM; // R11
		end else if (SYNTAX_FAULT_I && !err_ff) begin
			err_ff <= 1'b1;
			err_code_ff <= poller_pkg::CODE_SYNTAX; // R10
		end
	end
	assign FAULT_LAMP_O = err_ff; // R9 R10 R11

	// only the first syntax address is kept
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			syn_addr_ff <= poller_pkg::SYNADDR_RST;
			syn_held_ff <= 1'b0;
		end else if (SYNTAX_FAULT_I && !syn_held_ff) begin
			syn_addr_ff <= SYNTAX_ADDR_I; // R10 R17
			syn_held_ff <= 1'b1;
		end
	end

	// write channel: address and data taken in either order
	logic do_write;
	assign S_AXI_AWREADY_O = !aw_held_ff && !bvalid_ff;
	assign S_AXI_WREADY_O = !w_held_ff && !bvalid_ff;
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			aw_held_ff <= 1'b0;
			aw_idx_ff <= 3'h0;
			aw_ok_ff <= 1'b0;
		end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			aw_held_ff <= 1'b1;
			aw_idx_ff <= S_AXI_AWADDR_I[4:2];
			aw_ok_ff <= (S_AXI_AWADDR_I[4:2] <= poller_pkg::IDX_LAST) && (S_AXI_AWADDR_I >> 5) == '0;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			w_held_ff <= 1'b1;
			wdata_ff <= S_AXI_WDATA_I;
			wstrb_ff <= S_AXI_WSTRB_I;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= poller_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= aw_ok_ff ? poller_pkg::RESP_OKAY : poller_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY_I) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign S_AXI_BVALID_O = bvalid_ff;
	assign S_AXI_BRESP_O = bresp_ff;

	// writable registers, per byte lane; status words ignore writes
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			ctrl_ff <= poller_pkg::CTRL_RST;
		end else if (do_write && aw_ok_ff && aw_idx_ff == poller_pkg::IDX_CTRL) begin
			if (wstrb_ff[0]) begin
				ctrl_ff[7:0] <= wdata_ff[7:0];
			end
			if (wstrb_ff[1]) begin
				ctrl_ff[15:8] <= wdata_ff[15:8];
			end
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			irq_mask_ff <= poller_pkg::IRQ_RST;
		end else if (do_write && aw_ok_ff && aw_idx_ff == poller_pkg::IDX_IRQ_MASK && wstrb_ff[0]) begin
			irq_mask_ff <= wdata_ff[poller_pkg::IRQ_W-1:0];
		end
	end

	// read channel
	logic ar_hs;
	logic [2:0] ar_idx;
	logic ar_ok;
	logic [31:0] rd_val;
	assign S_AXI_ARREADY_O = !rvalid_ff;
	assign ar_hs = S_AXI_ARVALID_I && !rvalid_ff;
	assign ar_idx = S_AXI_ARADDR_I[4:2];
	assign ar_ok = (ar_idx <= poller_pkg::IDX_LAST) && (S_AXI_ARADDR_I >> 5) == '0;
	always_comb begin
		rd_val = 32'h0000_0000;
		case (ar_idx)
			poller_pkg::IDX_CTRL: rd_val[15:0] = ctrl_ff;
			poller_pkg::IDX_STATUS: rd_val[15:0] = status_word;
			poller_pkg::IDX_SYNADDR: rd_val[15:0] = syn_addr_ff;
			poller_pkg::IDX_IRQ_ST: rd_val[poller_pkg::IRQ_W-1:0] = irq_st_ff;
			poller_pkg::IDX_IRQ_MASK: rd_val[poller_pkg::IRQ_W-1:0] = irq_mask_ff;
			default: rd_val = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= poller_pkg::RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else if (ar_hs) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= ar_ok ? poller_pkg::RESP_OKAY : poller_pkg::RESP_SLVERR;
			rdata_ff <= ar_ok ? rd_val : 32'h0000_0000;
		end else if (S_AXI_RREADY_I) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign S_AXI_RVALID_O = rvalid_ff;
	assign S_AXI_RRESP_O = rresp_ff;
	assign S_AXI_RDATA_O = rdata_ff;

	// sticky events, cleared by reading them; a new event in the clearing cycle survives
	logic [poller_pkg::IRQ_W-1:0] irq_ev;
	logic irq_clr;
	always_comb begin
		irq_ev = '0;
		irq_ev[poller_pkg::IRQ_DONE] = state_ff == poller_pkg::ST_WAIT && POLL_DONE_I && running;
		irq_ev[poller_pkg::IRQ_ERR] = WDOG_FAIL_I || DM_RANGE_FAULT_I || SYNTAX_FAULT_I;
		irq_ev[poller_pkg::IRQ_TMO] = tif.expired;
	end
	assign irq_clr = ar_hs && ar_ok && ar_idx == poller_pkg::IDX_IRQ_ST;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RSTN_I) begin
			irq_st_ff <= poller_pkg::IRQ_RST;
		end else begin
			irq_st_ff <= (irq_clr ? poller_pkg::IRQ_RST : irq_st_ff) | irq_ev;
		end
	end
	assign IRQ_O = |(irq_st_ff & irq_mask_ff);

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);

	chk_stop_no_poll: assert property (!run_req |-> !POLL_REQ_O) // R3
		else $error("poll request while run digit is off");
	chk_zero_no_poll: assert property (cnt_bin == 7'h00 |-> !POLL_REQ_O) // R7
		else $error("poll request with zero components");
	// the sequencer may still sit in its wait state in the first cycle of the error; it leaves one edge later
	chk_fatal_no_poll: assert property (fatal_ff |-> !POLL_REQ_O ##1 state_ff != poller_pkg::ST_WAIT) // R2
		else $error("polling despite fatal error");
	chk_run_starts: assert property ($rose(running) ##1 running |-> POLL_REQ_O && POLL_UNIT_O == 5'h00) // R1
		else $error("run did not start polling at unit 0");
	chk_wdog_code: assert property (WDOG_FAIL_I && !fatal_ff |=> // R9
		status_word == {poller_pkg::DIGIT_ERR, poller_pkg::FLAG_STOP, poller_pkg::CODE_WDOG} && FAULT_LAMP_O)
		else $error("watchdog failure not reported");
	chk_dm_code: assert property (DM_RANGE_FAULT_I && !WDOG_FAIL_I && !fatal_ff |=> // R11
		status_word[7:0] == poller_pkg::CODE_DM && FAULT_LAMP_O)
		else $error("missing address fault not reported");
	chk_syntax_first: assert property (SYNTAX_FAULT_I && !syn_held_ff |=> // R10 R17
		syn_addr_ff == $past(SYNTAX_ADDR_I) ##1 syn_addr_ff == $past(syn_addr_ff))
		else $error("first syntax address not kept");
	chk_err_digits: assert property (err_ff |-> status_word[15:12] == poller_pkg::DIGIT_ERR // R8 R12 R13
		&& status_word[11:8] == poller_pkg::FLAG_STOP && status_word[7:0] == err_code_ff)
		else $error("error status digits wrong");
	chk_unit_report: assert property (irq_ev[poller_pkg::IRQ_DONE] |=> unit_ff == bin2bcd($past(idx_ff))) // R14
		else $error("completed unit not reported");
	chk_unit_zero: assert property (!run_req || cnt_bin == 7'h00 |=> unit_ff == poller_pkg::UNIT_NONE) // R15
		else $error("unit number not cleared");
	chk_run_flag: assert property (!err_ff |-> status_word[11:8] == (running ? poller_pkg::FLAG_RUN : // R16
		poller_pkg::FLAG_STOP))
		else $error("run flag does not follow running");
	chk_unit_range: assert property (state_ff == poller_pkg::ST_WAIT && running |-> 7'(idx_ff) < cnt_bin) // R6
		else $error("polled unit beyond count");

	cov_poll: cover property (POLL_REQ_O ##[1:20] POLL_DONE_I);
	cov_wrap: cover property (POLL_REQ_O && POLL_UNIT_O != 5'h00 ##[1:40] POLL_REQ_O && POLL_UNIT_O == 5'h00);
	cov_syntax: cover property (SYNTAX_FAULT_I && !err_ff);
	cov_irq: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

// file: test_serial_poller_control_status.sv
// self-checking bench of the serial poller control and status block
`timescale 1ns/1ns
`default_nettype none
module test_serial_poller_control_status;
	localparam int TICKS = 10;
	typedef struct packed {logic wr; logic [4:0] a; logic [31:0] d; logic [31:0] exp; logic [1:0] resp;} row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic wdog = 1'b0, synf = 1'b0, dmf = 1'b0, mute = 1'b0, pdone;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00, punit;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [15:0] syna = 16'h0000;
	logic [7:0] dly = 8'h05;
	logic awr, wrdy, bv, arr, rv, preq, lamp, irq;
	logic [1:0] bresp, rresp;
	int miscompares = 0;
	int samples_checked = 0;
	int req_cnt = 0;
	int cyc = 0;
	logic [4:0] unit_log [0:63];
	int req_time [0:63];
	row_t rows [10];
	serial_poller_control_status #(.TICK_CYCLES(TICKS)) dut (.SYS_CLK_I(clk), .RSTN_I(rstn),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
		.POLL_REQ_O(preq), .POLL_UNIT_O(punit), .POLL_DONE_I(pdone), .WDOG_FAIL_I(wdog),
		.SYNTAX_FAULT_I(synf), .SYNTAX_ADDR_I(syna), .DM_RANGE_FAULT_I(dmf),
		.FAULT_LAMP_O(lamp), .IRQ_O(irq));
	component_responder partner (.clk_i(clk), .req_i(preq), .mute_i(mute), .dly_i(dly), .done_o(pdone));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (preq === 1'b1) begin
			unit_log[req_cnt % 64] <= punit;
			req_time[req_cnt % 64] <= cyc;
			req_cnt <= req_cnt + 1;
		end
	end
	task stop_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// each task opens on a fresh edge so no signal is assigned twice in one step
	task axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa, pw;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awr === 1'b1) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (pw && wrdy === 1'b1) begin
				pw = 1'b0;
				wv <= 1'b0;
			end
		end
		while (bv !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
		end while (arr !== 1'b1);
		arv <= 1'b0;
		do begin
			@(posedge clk);
		end while (rv !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task rdchk(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(d, exp);
	endtask
	task fault(input logic [2:0] f, input logic [15:0] ad);
		@(posedge clk);
		{wdog, dmf, synf} <= f;
		syna <= ad;
		@(posedge clk);
		{wdog, dmf, synf} <= 3'h0;
	endtask
	task reset_dut;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
	endtask
	task wait_reqs(input int n);
		int b;
		b = req_cnt;
		while (req_cnt < b + n) @(posedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test();
	end
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		int base;
		int g;
		rows[0] = '{1'b0, 5'h00, 32'h0, 32'h0, poller_pkg::RESP_OKAY};
		rows[1] = '{1'b0, 5'h04, 32'h0, 32'h0, poller_pkg::RESP_OKAY};
		rows[2] = '{1'b0, 5'h08, 32'h0, 32'h0, poller_pkg::RESP_OKAY};
		rows[3] = '{1'b0, 5'h0C, 32'h0, 32'h0, poller_pkg::RESP_OKAY};
		rows[4] = '{1'b0, 5'h10, 32'h0, 32'h0, poller_pkg::RESP_OKAY};
		rows[5] = '{1'b1, 5'h10, 32'hFFFFFFFF, 32'h7, poller_pkg::RESP_OKAY};
		rows[6] = '{1'b1, 5'h04, 32'h0000FFFF, 32'h0, poller_pkg::RESP_OKAY};
		rows[7] = '{1'b1, 5'h00, 32'hABCD0390, 32'h0390, poller_pkg::RESP_OKAY};
		rows[8] = '{1'b0, 5'h04, 32'h0, 32'h0, poller_pkg::RESP_OKAY};
		rows[9] = '{1'b1, 5'h14, 32'h5, 32'h0, poller_pkg::RESP_SLVERR};
		reset_dut();
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, r);
				chk({30'h0, r}, {30'h0, rows[i].resp});
			end
			axi_rd(rows[i].a, d, r);
			chk(d, rows[i].exp);
			chk({30'h0, r}, {30'h0, rows[i].resp});
		end
		chk(req_cnt, 0);
		// full count of 32 with the timeout digit left at 0
		base = req_cnt;
		axi_wr(5'h00, 32'h3201, r);
		wait_reqs(33);
		for (int i = 0; i < 33; i++) chk({27'h0, unit_log[(base + i) % 64]}, i % 32);
		rdchk(5'h04, 32'h0131);
		axi_wr(5'h00, 32'h3200, r);
		cycles_wait: begin
			repeat (20) @(posedge clk);
		end
		base = req_cnt;
		repeat (30) @(posedge clk);
		chk(req_cnt, base);
		rdchk(5'h04, 32'h0000);
		axi_wr(5'h00, 32'h0001, r);
		repeat (30) @(posedge clk);
		chk(req_cnt, base);
		rdchk(5'h04, 32'h0000);
		// silent component: timeout digit 1 gives two base ticks
		mute <= 1'b1;
		axi_wr(5'h00, 32'h0111, r);
		axi_rd(5'h0C, d, r);
		base = req_cnt;
		wait_reqs(2);
		g = req_time[(base + 1) % 64] - req_time[base % 64];
		chk({31'h0, g >= 2 * TICKS && g <= 2 * TICKS + 2}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rdchk(5'h0C, 32'h4);
		chk({31'h0, irq}, 32'h0);
		axi_wr(5'h10, 32'h0, r);
		wait_reqs(1);
		chk({31'h0, irq}, 32'h0);
		rdchk(5'h0C, 32'h4);
		// errors during prompt polling; a later fatal code takes over the syntax code
		mute <= 1'b0;
		dly <= 8'h00;
		axi_wr(5'h00, 32'h0201, r);
		wait_reqs(2);
		fault(3'b001, 16'h1234);
		fault(3'b001, 16'h5678);
		repeat (2) @(posedge clk);
		base = req_cnt;
		repeat (20) @(posedge clk);
		chk(req_cnt, base);
		chk({31'h0, lamp}, 32'h1);
		rdchk(5'h04, 32'h8002);
		rdchk(5'h08, 32'h1234);
		rdchk(5'h0C, 32'h7);
		fault(3'b010, 16'h0000);
		rdchk(5'h04, 32'h8015);
		fault(3'b100, 16'h0000);
		rdchk(5'h04, 32'h8015);
		reset_dut();
		rdchk(5'h04, 32'h0000);
		chk({31'h0, lamp}, 32'h0);
		fault(3'b100, 16'h0000);
		axi_wr(5'h00, 32'h0201, r);
		base = req_cnt;
		repeat (20) @(posedge clk);
		chk(req_cnt, base);
		rdchk(5'h04, 32'h8001);
		chk({31'h0, lamp}, 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire

// file: tick_divider.sv
// divider that makes the one-cycle base tick of the response timer
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
	parameter int CYCLES = poller_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	timer_if.div tif
);
	localparam int CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	initial begin
		if (CYCLES < 2) begin
			$error("tick_divider: CYCLES must be at least 2");
		end
	end
	logic [CW-1:0] cnt_ff;
	// restart on start so the first tick comes one full period later
	always_ff @(posedge clk_i) begin
		if (!rstn_i || tif.start || cnt_ff == LAST) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + CW'(1);
		end
	end
	assign tif.tick = (cnt_ff == LAST) && !tif.start;
endmodule
`default_nettype wire

// file: timer_if.sv
// signals between the poll sequencer, the response timer and its tick divider
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
	logic start;
	logic stop;
	logic [3:0] ticks;
	logic tick;
	logic expired;
	modport ctl (output start, output stop, output ticks, input expired);
	modport tmr (input start, input stop, input ticks, input tick, output expired);
	modport div (input start, output tick);
endinterface
`default_nettype wire
